// >>> rtl/spi_fe_pkg.sv
/*
 * spi_fe_pkg: constants and carriers for the serial front end of a small
 * spi memory: register map, status byte layout, opcodes, pin bundle.
 * assumes: nothing beyond a systemverilog compiler.
 */
`default_nettype none
package spi_fe_pkg;

	// register byte addresses, one aligned 32-bit word each
	localparam logic [7:0] REG_STATUS  = 8'h00; // ro: link state and status byte
	localparam logic [7:0] REG_RXINFO  = 8'h04; // ro: last byte in, last executed opcode
	localparam logic [7:0] REG_TXDATA  = 8'h08; // rw: byte sent for memory reads
	localparam logic [7:0] REG_NVBITS  = 8'h0c; // rw: retained protection bits
	localparam logic [7:0] REG_BUSYCLR = 8'h10; // w1c: bit0 ends the internal write cycle

	// status byte field positions
	localparam int BIT_BUSY = 0;
	localparam int BIT_WEL  = 1;
	localparam int BIT_BPLO = 2;
	localparam int BIT_BPHI = 3;
	localparam int BIT_LOCK = 7;

	// status register word extras
	localparam int BIT_SELECTED = 8;
	localparam int BIT_PAUSED   = 9;
	localparam int BIT_STANDBY  = 10;
	localparam int BIT_PRIMED   = 11;
	localparam int BIT_HWPROT   = 12;
	localparam int POS_BITCNT   = 16;

	// instruction codes
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_WRSR  = 8'h01;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;

	// bit counter width, and bit counts at which a phase is complete
	localparam int          CNT_W       = 16;
	localparam logic [15:0] CNT_OPCODE  = 16'h0008;
	localparam logic [15:0] CNT_WRSR    = 16'h0010;
	localparam logic [15:0] CNT_READHDR = 16'h0020;
	localparam logic [15:0] CNT_WRITE   = 16'h0028;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// serial pins as seen by the device
	typedef struct packed {
		logic sclk;
		logic csN;
		logic mosi;
		logic pauseN;
		logic protectN;
	} spi_pins_s;

	// non-volatile protection bits
	typedef struct packed {
		logic lock;
		logic bpHi;
		logic bpLo;
	} nv_bits_s;

endpackage
`default_nettype wire

// >>> rtl/spi_eeprom_serial_front_end.sv
/*
 * spi_eeprom_serial_front_end: device side serial front end of a small spi
 * memory. pins are oversampled on core_clk; registers over axi4-lite.
 * assumes: serial clock well below core_clk/4, pins asynchronous to core_clk,
 * rst_n stands for the internal power-on reset.
 */
`default_nettype none
// Operation
// - output bit changes only after falling edge
// - input bit captured on each rising edge
// - deselected means output floats
// - deselected and idle means standby, selected active
// - select only after a falling select edge
// - all input bytes arrive msb first
// - output msb first, from first falling edge
// - first bit sampled on first rising edge
// - instructions ignored while reset is held
// - reset leaves deselected, latch and busy cleared
// - reset keeps lock and protect bits
// - pause floats output, ignores clock and data
// - pause starts on pause low, clock low
// - pause ends on pause high, clock low
// - deselect while paused resets interface state
// - protect pin freezes the protect bits; the code freezes them only while the lock bit is set
// - execute only if deselect follows last bit
// - writes need bit count multiple of eight
module spi_eeprom_serial_front_end #(
	parameter int ADDR_W = 8
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire spi_fe_pkg::spi_pins_s pinsIn,
	output logic                       misoOut,
	output logic                       misoOe,
	output logic                       activePower,
	output logic                       standbyPower,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);

	typedef struct packed {
		spi_fe_pkg::spi_pins_s       sync1;
		spi_fe_pkg::spi_pins_s       sync2;
		logic                        clkPrev;
		logic                        csPrev;
		logic                        primed;
		logic                        selected;
		logic                        paused;
		logic                        outLive;
		logic [spi_fe_pkg::CNT_W-1:0] bitCnt;
		logic [7:0]                  shiftIn;
		logic [7:0]                  shiftOut;
		logic [7:0]                  opcode;
		logic [7:0]                  dataByte;
		logic [7:0]                  lastRx;
		logic [7:0]                  lastExec;
		logic [7:0]                  txData;
		logic                        write_enable_latch;
		logic                        busy;
		spi_fe_pkg::nv_bits_s        nv;
		logic                        awGot;
		logic                        wGot;
		logic [ADDR_W-1:0]           awAddr;
		logic [31:0]                 wData;
		logic [3:0]                  wStrb;
		logic                        bValid;
		logic [1:0]                  bResp;
		logic                        rValid;
		logic [31:0]                 rData;
		logic [1:0]                  rResp;
	} state_s;

	state_s q;
	state_s d;

	logic       clkS;
	logic       csS;
	logic       mosiS;
	logic       pauseS;
	logic       protS;
	logic       riseEv;
	logic       fallEv;
	logic       csFall;
	logic       csRise;
	logic       hwProt;
	logic       readOn;
	logic       canExec;
	logic [7:0] statusByte;
	logic [7:0] byteIn;

	// synchronised pin levels and their edges, all from the second stage
	assign clkS   = q.sync2.sclk;
	assign csS    = q.sync2.csN;
	assign mosiS  = q.sync2.mosi;
	assign pauseS = q.sync2.pauseN;
	assign protS  = q.sync2.protectN;
	assign riseEv = clkS & ~q.clkPrev;
	assign fallEv = ~clkS & q.clkPrev;
	assign csFall = ~csS & q.csPrev;
	assign csRise = csS & ~q.csPrev;
	assign hwProt = q.nv.lock & ~protS;
	assign byteIn = {q.shiftIn[6:0], mosiS};

	// status byte as shifted out, unused bits read as zero
	always_comb begin
		statusByte = 8'h00;
		statusByte[spi_fe_pkg::BIT_BUSY] = q.busy;
		statusByte[spi_fe_pkg::BIT_WEL]  = q.write_enable_latch;
		statusByte[spi_fe_pkg::BIT_BPLO] = q.nv.bpLo;
		statusByte[spi_fe_pkg::BIT_BPHI] = q.nv.bpHi;
		statusByte[spi_fe_pkg::BIT_LOCK] = q.nv.lock;
	end

	// output phase starts once the whole read header is in
	assign readOn = ((q.opcode == spi_fe_pkg::OP_RDSR) && (q.bitCnt >= spi_fe_pkg::CNT_OPCODE))
		|| ((q.opcode == spi_fe_pkg::OP_READ) && (q.bitCnt >= spi_fe_pkg::CNT_READHDR));

	// deselect lands between the last rising edge and the next one only
	// when the count is a whole number of bytes; a paused deselect aborts
	assign canExec = q.selected && !q.paused && (q.bitCnt != '0) && (q.bitCnt[2:0] == 3'h0);

	// next-state logic for link, status and bus slave
	always_comb begin
		d = q;
		d.sync1 = pinsIn;
		d.sync2 = q.sync1;
		d.clkPrev = clkS;
		d.csPrev = csS;
		if (csS) begin
			d.primed = 1'b1;
		end

		// pause only follows the pin while clock is low, so a change
		// made with clock high simply waits for the low phase
		if (q.selected && !clkS) begin
			d.paused = ~pauseS;
		end

		if (csFall && q.primed) begin
			d.selected = 1'b1;
			d.paused = 1'b0;
			d.bitCnt = '0;
			d.opcode = spi_fe_pkg::RST_BYTE;
			d.outLive = 1'b0;
		end else if (q.selected && !q.paused) begin
			if (riseEv) begin
				d.shiftIn = byteIn;
				d.bitCnt = q.bitCnt + 1'b1;
				if (q.bitCnt[2:0] == 3'h7) begin
					d.lastRx = byteIn;
					if (q.bitCnt == (spi_fe_pkg::CNT_OPCODE - 1'b1)) begin
						d.opcode = byteIn;
					end
					if (q.bitCnt == (spi_fe_pkg::CNT_WRSR - 1'b1)) begin
						d.dataByte = byteIn;
					end
				end
			end
			// new byte on a byte boundary, otherwise next bit, msb first
			if (fallEv && readOn) begin
				d.outLive = 1'b1;
				if (q.bitCnt[2:0] == 3'h0) begin
					d.shiftOut = (q.opcode == spi_fe_pkg::OP_RDSR) ? statusByte : q.txData;
				end else begin
					d.shiftOut = {q.shiftOut[6:0], 1'b0};
				end
			end
		end

		// bus write; busy clear comes first so a cycle start wins over it
		if (q.awGot && q.wGot && !q.bValid) begin
			d.awGot = 1'b0;
			d.wGot = 1'b0;
			d.bValid = 1'b1;
			d.bResp = spi_fe_pkg::RESP_OKAY;
			if (q.awAddr == spi_fe_pkg::REG_TXDATA) begin
				if (q.wStrb[0]) begin
					d.txData = q.wData[7:0];
				end
			end else if (q.awAddr == spi_fe_pkg::REG_NVBITS) begin
				if (q.wStrb[0] && !q.busy) begin
					d.nv.lock = q.wData[spi_fe_pkg::BIT_LOCK];
					d.nv.bpHi = q.wData[spi_fe_pkg::BIT_BPHI];
					d.nv.bpLo = q.wData[spi_fe_pkg::BIT_BPLO];
				end
			end else if (q.awAddr == spi_fe_pkg::REG_BUSYCLR) begin
				if (q.wStrb[0] && q.wData[0]) begin
					d.busy = 1'b0;
				end
			end else if ((q.awAddr == spi_fe_pkg::REG_STATUS)
				|| (q.awAddr == spi_fe_pkg::REG_RXINFO)) begin
				d.bResp = spi_fe_pkg::RESP_OKAY; // read-only, write ignored
			end else begin
				d.bResp = spi_fe_pkg::RESP_SLVERR;
			end
		end

		// deselect ends the frame and executes a complete instruction
		if (csRise) begin
			d.selected = 1'b0;
			d.paused = 1'b0;
			d.bitCnt = '0;
			d.outLive = 1'b0;
			if (canExec) begin
				d.lastExec = q.opcode;
				case (q.opcode)
					spi_fe_pkg::OP_WREN: begin
						d.write_enable_latch = 1'b1;
					end
					spi_fe_pkg::OP_WRDI: begin
						d.write_enable_latch = 1'b0;
					end
					spi_fe_pkg::OP_WRSR: begin
						if (q.write_enable_latch && !hwProt && (q.bitCnt == spi_fe_pkg::CNT_WRSR)) begin
							d.nv.lock = q.dataByte[spi_fe_pkg::BIT_LOCK];
							d.nv.bpHi = q.dataByte[spi_fe_pkg::BIT_BPHI];
							d.nv.bpLo = q.dataByte[spi_fe_pkg::BIT_BPLO];
							d.write_enable_latch = 1'b0;
							d.busy = 1'b1;
						end
					end
					spi_fe_pkg::OP_WRITE: begin
						if (q.write_enable_latch && (q.bitCnt >= spi_fe_pkg::CNT_WRITE)) begin
							d.write_enable_latch = 1'b0;
							d.busy = 1'b1;
						end
					end
					default: begin
						d.lastExec = q.opcode;
					end
				endcase
			end
		end

		// write address and data may come in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.awGot = 1'b1;
			d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.wGot = 1'b1;
			d.wData = s_axi_wdata;
			d.wStrb = s_axi_wstrb;
		end
		if (q.bValid && s_axi_bready) begin
			d.bValid = 1'b0;
		end

		// read channel, one outstanding read
		if (s_axi_arvalid && s_axi_arready) begin
			d.rValid = 1'b1;
			d.rResp = spi_fe_pkg::RESP_OKAY;
			d.rData = 32'h0000_0000;
			if (s_axi_araddr == spi_fe_pkg::REG_STATUS) begin
				d.rData[7:0] = statusByte;
				d.rData[spi_fe_pkg::BIT_SELECTED] = q.selected;
				d.rData[spi_fe_pkg::BIT_PAUSED] = q.paused;
				d.rData[spi_fe_pkg::BIT_STANDBY] = ~q.selected & ~q.busy;
				d.rData[spi_fe_pkg::BIT_PRIMED] = q.primed;
				d.rData[spi_fe_pkg::BIT_HWPROT] = hwProt;
				d.rData[spi_fe_pkg::POS_BITCNT +: spi_fe_pkg::CNT_W] = q.bitCnt;
			end else if (s_axi_araddr == spi_fe_pkg::REG_RXINFO) begin
				d.rData[15:0] = {q.lastExec, q.lastRx};
			end else if (s_axi_araddr == spi_fe_pkg::REG_TXDATA) begin
				d.rData[7:0] = q.txData;
			end else if (s_axi_araddr == spi_fe_pkg::REG_NVBITS) begin
				d.rData[spi_fe_pkg::BIT_LOCK] = q.nv.lock;
				d.rData[spi_fe_pkg::BIT_BPHI] = q.nv.bpHi;
				d.rData[spi_fe_pkg::BIT_BPLO] = q.nv.bpLo;
			end else if (s_axi_araddr == spi_fe_pkg::REG_BUSYCLR) begin
				d.rData[0] = q.busy;
			end else begin
				d.rResp = spi_fe_pkg::RESP_SLVERR;
			end
		end
		if (q.rValid && s_axi_rready) begin
			d.rValid = 1'b0;
		end
	end

	// state register; the retained protection bits survive reset on
	// purpose, everything else returns to its idle value
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.nv <= q.nv;
		end else if (ce) begin
			q <= d;
		end
	end

	// bus handshakes; readies drop with ce so no beat is lost
	assign s_axi_awready = ce & ~q.awGot & ~q.bValid;
	assign s_axi_wready  = ce & ~q.wGot & ~q.bValid;
	assign s_axi_bvalid  = q.bValid;
	assign s_axi_bresp   = q.bResp;
	assign s_axi_arready = ce & ~q.rValid;
	assign s_axi_rvalid  = q.rValid;
	assign s_axi_rdata   = q.rData;
	assign s_axi_rresp   = q.rResp;

	// serial output and power mode
	assign misoOut      = q.shiftOut[7];
	assign misoOe       = q.selected & ~q.paused & q.outLive;
	assign activePower  = q.selected;
	assign standbyPower = ~q.selected & ~q.busy;

	property p_float_deselected;
		@(posedge core_clk) disable iff (!rst_n)
		!q.selected |-> !misoOe;
	endproperty
	a_float_deselected: assert property (p_float_deselected)
		else $error("output driven while deselected");

	property p_float_paused;
		@(posedge core_clk) disable iff (!rst_n)
		q.paused |-> !misoOe;
	endproperty
	a_float_paused: assert property (p_float_paused)
		else $error("output driven while paused");

	property p_out_on_fall;
		@(posedge core_clk) disable iff (!rst_n)
		$past(rst_n) && $changed(misoOut) |-> $past(fallEv) && $past(q.selected);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("output bit changed without falling clock");

	property p_count_on_rise;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && riseEv && q.selected && !q.paused && !csRise && !csFall)
			|=> q.bitCnt == $past(q.bitCnt) + 1'b1;
	endproperty
	a_count_on_rise: assert property (p_count_on_rise)
		else $error("rising clock not counted");

	property p_needs_fall;
		@(posedge core_clk) disable iff (!rst_n)
		!q.primed |-> !q.selected;
	endproperty
	a_needs_fall: assert property (p_needs_fall)
		else $error("selected without prior high select");

	property p_reset_state;
		@(posedge core_clk) disable iff (1'b0)
		// only a reset entered from run; the retained bits are unknown at power-up
		rst_n ##1 !rst_n |=> !q.write_enable_latch && !q.busy && !q.selected && (q.nv == $past(q.nv));
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");

	property p_pause_clk_low;
		@(posedge core_clk) disable iff (!rst_n)
		$changed(q.paused) && q.selected && $past(q.selected) |-> !$past(clkS);
	endproperty
	a_pause_clk_low: assert property (p_pause_clk_low)
		else $error("pause changed with clock high");

	property p_abort_paused;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && csRise && q.paused) |=> !q.paused && (q.bitCnt == '0)
			&& (q.lastExec == $past(q.lastExec)) && (q.write_enable_latch == $past(q.write_enable_latch));
	endproperty
	a_abort_paused: assert property (p_abort_paused)
		else $error("paused deselect did not abort");

	property p_busy_whole_bytes;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(q.busy) |-> $past(q.bitCnt[2:0]) == 3'h0 && $past(csRise);
	endproperty
	a_busy_whole_bytes: assert property (p_busy_whole_bytes)
		else $error("write accepted on partial byte");

	property p_protect_frozen;
		@(posedge core_clk) disable iff (!rst_n)
		(ce && csRise && hwProt) |=> q.nv == $past(q.nv);
	endproperty
	a_protect_frozen: assert property (p_protect_frozen)
		else $error("protect bits changed while frozen");

endmodule
`default_nettype wire

// >>> test/spi_master_model.sv
/*
 * spi_master_model: bus master on the serial pins of the memory front end,
 * mode 0 or mode 3, msb first, with pause and write-protect control.
 * assumes: core_clk at 4 ns paces it, 20 cycles a half period (160 ns link).
 */
`default_nettype none
module spi_master_model (
	input  wire logic                  core_clk,
	input  wire logic                  misoOut,
	input  wire logic                  misoOe,
	output var  spi_fe_pkg::spi_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;

	logic cpol     = 1'b0;
	logic lastMiso = 1'b0;
	logic misoLine;

	// select low at power-up on purpose, never seen high before reset ends
	initial pins = '{sclk: 1'b0, csN: 1'b0, mosi: 1'b0, pauseN: 1'b1, protectN: 1'b1};

	// released line shows the inverse of its last level, no pull on it
	always @(posedge core_clk)
		if (misoOe)
			lastMiso <= misoOut;
	assign misoLine = misoOe ? misoOut : ~lastMiso;

	task automatic half();
		repeat (20) @(posedge core_clk);
	endtask

	// data set in the low phase, data out sampled at the rise
	task automatic bit1(input logic b, output logic r);
		pins.sclk <= 1'b0;
		pins.mosi <= b;
		half();
		pins.sclk <= 1'b1;
		r = misoLine;
		half();
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
			bit1(tx[i], rx[i]);
	endtask

	task automatic sel(input logic mode3);
		cpol = mode3;
		pins.sclk <= mode3;
		half();
		pins.csN <= 1'b0;
		half();
	endtask

	// clock back to idle first, so select rises before any further rise
	task automatic desel();
		pins.sclk <= cpol;
		half();
		pins.csN <= 1'b1;
		half();
	endtask

	// pause pin moves only with the clock low
	task automatic pause(input logic p);
		pins.sclk <= 1'b0;
		half();
		pins.pauseN <= p;
		half();
	endtask

	// changed only between frames, never inside a write
	task automatic protect(input logic p);
		pins.protectN <= p;
	endtask
endmodule
`default_nettype wire

// >>> test/test_spi_eeprom_serial_front_end.sv
/*
 * test_spi_eeprom_serial_front_end: self-checking bench, axi4-lite tasks,
 * spi master model on the pins, one task per scenario.
 * assumes: register map and status bits of spi_fe_pkg, 250 MHz core_clk.
 */
`default_nettype none
module test_spi_eeprom_serial_front_end;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] BUSY = 32'h1 << spi_fe_pkg::BIT_BUSY;
	localparam logic [31:0] WRITE_ENABLE_LATCH  = 32'h1 << spi_fe_pkg::BIT_WEL;
	localparam logic [31:0] SEL  = 32'h1 << spi_fe_pkg::BIT_SELECTED;
	localparam logic [31:0] STBY = 32'h1 << spi_fe_pkg::BIT_STANDBY;

	logic                  core_clk = 1'b0;
	logic                  rst_n    = 1'b0;
	logic                  ce       = 1'b1;
	logic [3:0]            wstrb    = 4'hf;
	spi_fe_pkg::spi_pins_s pins;
	logic                  misoOut;
	logic                  misoOe;
	logic                  activePower;
	logic                  standbyPower;
	logic [7:0]            awaddr   = 8'h00;
	logic [7:0]            araddr   = 8'h00;
	logic [31:0]           wdata    = 32'h0;
	logic [31:0]           rdata;
	logic                  awvalid  = 1'b0;
	logic                  wvalid   = 1'b0;
	logic                  bready   = 1'b0;
	logic                  arvalid  = 1'b0;
	logic                  rready   = 1'b0;
	logic                  awready;
	logic                  wready;
	logic                  bvalid;
	logic                  arready;
	logic                  rvalid;
	logic [1:0]            bresp;
	logic [1:0]            rresp;
	logic [1:0]            lastResp;
	int                    mismatches = 0;
	int                    checksDone = 0;

	spi_eeprom_serial_front_end dut (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .pinsIn(pins),
		.misoOut(misoOut), .misoOe(misoOe), .activePower(activePower),
		.standbyPower(standbyPower), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	spi_master_model m (.core_clk(core_clk), .misoOut(misoOut), .misoOe(misoOe), .pins(pins));

	// 250 MHz core clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		lastResp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (!rvalid);
		d = rdata;
		lastResp = rresp;
		rready <= 1'b0;
	endtask

	task automatic st(input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] d;
		rd(spi_fe_pkg::REG_STATUS, d);
		chk("status", exp, d & mask);
	endtask

	task automatic cmd(input logic [7:0] op, input logic mode3);
		logic [7:0] rx;
		m.sel(mode3);
		m.xfer(op, rx);
		m.desel();
	endtask

	task automatic wrsr(input logic [7:0] v);
		logic [7:0] rx;
		m.sel(1'b0);
		m.xfer(spi_fe_pkg::OP_WRSR, rx);
		m.xfer(v, rx);
		m.desel();
	endtask

	// select held low through power-up must not select
	task automatic tPowerUp();
		logic [7:0] rx;
		m.xfer(spi_fe_pkg::OP_WREN, rx);
		chk("active", 32'h0, {31'h0, activePower});
		m.desel();
		st(WRITE_ENABLE_LATCH | SEL, 32'h0);
	endtask

	// a frame sent during reset is lost; retained bits survive
	task automatic tReset();
		logic [31:0] d;
		cmd(spi_fe_pkg::OP_WREN, 1'b0);
		st(WRITE_ENABLE_LATCH, WRITE_ENABLE_LATCH);
		rst_n <= 1'b0;
		cmd(spi_fe_pkg::OP_WREN, 1'b0);
		rst_n <= 1'b1;
		@(posedge core_clk);
		st(WRITE_ENABLE_LATCH | BUSY | SEL | STBY, STBY);
		rd(spi_fe_pkg::REG_NVBITS, d);
		chk("nvbits", 32'h8c, d);
	endtask

	task automatic tRdsr();
		logic [7:0] rx;
		for (int mode = 0; mode < 2; mode++) begin
			cmd(mode[0] ? spi_fe_pkg::OP_WRDI : spi_fe_pkg::OP_WREN, mode[0]);
			m.sel(mode[0]);
			chk("active", 32'h1, {31'h0, activePower});
			m.xfer(spi_fe_pkg::OP_RDSR, rx);
			m.xfer(8'h00, rx);
			chk("status byte", mode[0] ? 32'h8c : 32'h8e, {24'h0, rx});
			m.desel();
			chk("drive", 32'h0, {31'h0, misoOe});
			chk("standby", 32'h1, {31'h0, standbyPower});
		end
	endtask

	task automatic tRead();
		logic [7:0] rx;
		wr(spi_fe_pkg::REG_TXDATA, 32'ha5);
		m.sel(1'b0);
		m.xfer(spi_fe_pkg::OP_READ, rx);
		for (int i = 0; i < 3; i++)
			m.xfer(8'hff, rx);
		for (int i = 0; i < 2; i++) begin
			m.xfer(8'h00, rx);
			chk("read byte", 32'ha5, {24'h0, rx});
		end
		m.desel();
	endtask

	// odd bit count, then hardware lock, then a real status write
	task automatic tWrsr();
		logic [31:0] d;
		logic [7:0]  rx;
		logic        b;
		cmd(spi_fe_pkg::OP_WREN, 1'b0);
		m.sel(1'b0);
		m.xfer(spi_fe_pkg::OP_WRSR, rx);
		m.xfer(8'h00, rx);
		m.bit1(1'b0, b);
		m.desel();
		st(WRITE_ENABLE_LATCH | BUSY, WRITE_ENABLE_LATCH);
		m.protect(1'b0);
		wrsr(8'h00);
		rd(spi_fe_pkg::REG_NVBITS, d);
		chk("nvbits", 32'h8c, d);
		m.protect(1'b1);
		wrsr(8'h84);
		st(WRITE_ENABLE_LATCH | BUSY, BUSY);
		chk("standby", 32'h0, {31'h0, standbyPower});
		wr(spi_fe_pkg::REG_BUSYCLR, 32'h1);
		rd(spi_fe_pkg::REG_NVBITS, d);
		chk("nvbits", 32'h84, d);
	endtask

	// pause mid-byte with one clock pulse inside, then deselect while paused
	task automatic tPause();
		logic [7:0] rx;
		logic       b;
		m.sel(1'b0);
		m.xfer(spi_fe_pkg::OP_RDSR, rx);
		for (int i = 7; i >= 0; i--) begin
			if (i == 3) begin
				m.pause(1'b0);
				chk("drive", 32'h0, {31'h0, misoOe});
				m.bit1(1'b1, b);
				m.pause(1'b1);
			end
			m.bit1(1'b0, rx[i]);
		end
		chk("paused byte", 32'h84, {24'h0, rx});
		m.desel();
		m.sel(1'b0);
		for (int i = 0; i < 4; i++)
			m.bit1(1'b0, b);
		m.pause(1'b0);
		m.desel();
		m.pause(1'b1);
		cmd(spi_fe_pkg::OP_WREN, 1'b0);
		st(WRITE_ENABLE_LATCH, WRITE_ENABLE_LATCH);
	endtask

	task automatic tAxi();
		logic [31:0] d;
		wr(8'h20, 32'h1);
		chk("bresp", {30'h0, spi_fe_pkg::RESP_SLVERR}, {30'h0, lastResp});
		rd(8'h24, d);
		chk("rresp", {30'h0, spi_fe_pkg::RESP_SLVERR}, {30'h0, lastResp});
		// low byte strobe off: the transmit byte must keep its value
		wstrb <= 4'h0;
		wr(spi_fe_pkg::REG_TXDATA, 32'h5a);
		wstrb <= 4'hf;
		rd(spi_fe_pkg::REG_TXDATA, d);
		chk("txdata", 32'ha5, d);
		// clock enable low drops both address readies
		ce <= 1'b0;
		@(posedge core_clk);
		chk("arready", 32'h0, {31'h0, arready});
		chk("awready", 32'h0, {31'h0, awready});
		ce <= 1'b1;
		@(posedge core_clk);
		chk("arready", 32'h1, {31'h0, arready});
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		tPowerUp();
		wr(spi_fe_pkg::REG_NVBITS, 32'h8c);
		tReset();
		tRdsr();
		tRead();
		tWrsr();
		tPause();
		tAxi();
		printVerdict();
	end

	// whole run needs some 10000 cycles; stop a hang well after
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		printVerdict();
	end
endmodule
`default_nettype wire
